// ==== hdl/fca_accept.v ====
// Flash command-acceptance state machine with status flags
`include "fca_regs.vh"
module fca_accept (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Command from software
  input wire cmd_valid_i,
  input wire [`FCA_CMD_W-1:0] cmd_code_i,
  input wire prog_in_erase_ok_i,
  // ECC control bits
  input wire error_detect_enable_i,
  input wire error_correct_enable_i,
  // Status
  output reg ready_flag_o,
  output reg suspend_ready_flag_o,
  output reg erase_suspended_flag_o,
  output reg program_suspended_flag_o,
  output reg command_lock_flag_o,
  output reg cmd_accepted_o,
  output reg flash_interface_error_irq_o
);
  localparam [8:0] ST_PE = 9'h001;
  localparam [8:0] ST_PIE = 9'h002;
  localparam [8:0] ST_SUS = 9'h004;
  localparam [8:0] ST_LK2 = 9'h008;
  localparam [8:0] ST_PSP = 9'h010;
  localparam [8:0] ST_ESP = 9'h020;
  localparam [8:0] ST_LK0 = 9'h040;
  localparam [8:0] ST_LK1 = 9'h080;
  localparam [8:0] ST_IDL = 9'h100;

  reg [8:0] state_q;
  reg [8:0] state_d;
  reg erase_op_q;
  reg erase_op_d;
  reg esus_q;
  reg esus_d;
  reg psus_q;
  reg psus_d;
  reg start;
  reg [`FCA_OP_W-1:0] op;
  reg abort;
  wire accept;
  wire done;
  wire cmd_take;

  assign cmd_take = cmd_valid_i;

  fca_cmd_decode u_dec (
    .state_i(state_q),
    .cmd_i(cmd_code_i),
    .prog_in_erase_ok_i(prog_in_erase_ok_i),
    .accept_o(accept)
  );

  fca_busy_timer u_tmr (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .start_i(start),
    .op_i(op),
    .abort_i(abort),
    .done_o(done)
  );

  always @* begin
    state_d = state_q;
    erase_op_d = erase_op_q;
    esus_d = esus_q;
    psus_d = psus_q;
    start = 1'b0;
    op = `FCA_OP_PROGRAM;
    abort = 1'b0;
    if (cmd_take & ~accept & ~state_q[6] & ~state_q[7]) begin
      // Any rejected command locks, remembering the ready level
      abort = 1'b1;
      if (state_q == ST_PSP || state_q == ST_ESP || state_q == ST_IDL) begin
        state_d = ST_LK1;
      end else begin
        state_d = ST_LK0;
      end
    end else if (cmd_take & accept) begin
      case (cmd_code_i)
        `FCA_CMD_PROGRAM: begin
          start = 1'b1;
          op = `FCA_OP_PROGRAM;
          erase_op_d = 1'b0;
          state_d = (state_q == ST_ESP) ? ST_PIE : ST_PE;
        end
        `FCA_CMD_BLOCK_ERASE: begin
          start = 1'b1;
          op = `FCA_OP_ERASE;
          erase_op_d = 1'b1;
          state_d = ST_PE;
        end
        `FCA_CMD_SUSPEND: begin
          start = 1'b1;
          op = `FCA_OP_SUSPEND;
          state_d = ST_SUS;
        end
        `FCA_CMD_RESUME: begin
          start = 1'b1;
          op = esus_q ? `FCA_OP_ERASE : `FCA_OP_PROGRAM;
          erase_op_d = esus_q;
          esus_d = 1'b0;
          psus_d = 1'b0;
          state_d = ST_PE;
        end
        `FCA_CMD_LOCK_READ2: begin
          start = 1'b1;
          op = `FCA_OP_LOCKREAD;
          state_d = ST_LK2;
        end
        `FCA_CMD_STATUS_CLEAR: begin
          if (state_q == ST_LK1) begin
            state_d = esus_q ? ST_ESP : (psus_q ? ST_PSP : ST_IDL);
          end
        end
        default: state_d = state_q;
      endcase
    end else if (done) begin
      case (state_q)
        ST_PE: state_d = ST_IDL;
        ST_PIE: state_d = ST_ESP;
        ST_SUS: begin
          esus_d = erase_op_q;
          psus_d = ~erase_op_q;
          state_d = erase_op_q ? ST_ESP : ST_PSP;
        end
        ST_LK2: state_d = esus_q ? ST_ESP : (psus_q ? ST_PSP : ST_IDL);
        default: state_d = state_q;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= ST_IDL;
      erase_op_q <= 1'b0;
      esus_q <= 1'b0;
      psus_q <= 1'b0;
      ready_flag_o <= 1'b0;
      suspend_ready_flag_o <= 1'b0;
      erase_suspended_flag_o <= 1'b0;
      program_suspended_flag_o <= 1'b0;
      command_lock_flag_o <= 1'b0;
      cmd_accepted_o <= 1'b0;
      flash_interface_error_irq_o <= 1'b0;
    end else begin
      state_q <= state_d;
      erase_op_q <= erase_op_d;
      esus_q <= esus_d;
      psus_q <= psus_d;
      ready_flag_o <= state_d[4] | state_d[5] | state_d[7] | state_d[8];
      suspend_ready_flag_o <= state_d[0];
      erase_suspended_flag_o <= state_d[1] | state_d[5] | ((state_d[2] | state_d[3] | state_d[6] | state_d[7]) & esus_d);
      program_suspended_flag_o <= state_d[4] | ((state_d[2] | state_d[3] | state_d[6] | state_d[7]) & psus_d);
      command_lock_flag_o <= state_d[6] | state_d[7];
      cmd_accepted_o <= cmd_take & accept;
      flash_interface_error_irq_o <= (state_d[6] | state_d[7]) & ~(state_q[6] | state_q[7])
        & (error_detect_enable_i | error_correct_enable_i);
    end
  end
endmodule // fca_accept

// ==== shared/fca_regs.vh ====
// Command codes, operation codes and timing constants of the flash command-acceptance block
`ifndef FCA_REGS_VH
`define FCA_REGS_VH

// Command codes on cmd_code_i
`define FCA_CMD_W 4
`define FCA_CMD_NORMAL 4'h0
`define FCA_CMD_STATUS_READ 4'h1
`define FCA_CMD_LOCK_READ1 4'h2
`define FCA_CMD_CLOCK_NOTIFY 4'h3
`define FCA_CMD_PROGRAM 4'h4
`define FCA_CMD_BLOCK_ERASE 4'h5
`define FCA_CMD_SUSPEND 4'h6
`define FCA_CMD_RESUME 4'h7
`define FCA_CMD_STATUS_CLEAR 4'h8
`define FCA_CMD_LOCK_READ2 4'h9

// Operation kind reported to the busy timer
`define FCA_OP_W 2
`define FCA_OP_PROGRAM 2'h0
`define FCA_OP_ERASE 2'h1
`define FCA_OP_SUSPEND 2'h2
`define FCA_OP_LOCKREAD 2'h3

// Timer width and default durations in clock cycles
`define FCA_TMR_W 16
`define FCA_PROG_CYC 16'h0040
`define FCA_ERASE_CYC 16'h0100
`define FCA_SUSP_CYC 16'h0010
`define FCA_LKRD_CYC 16'h0004

`endif

// ==== hdl/fca_busy_timer.v ====
// Busy timer that times one flash operation and pulses on completion
`include "fca_regs.vh"
module fca_busy_timer #(
  parameter [`FCA_TMR_W-1:0] PROG_CYC = `FCA_PROG_CYC,
  parameter [`FCA_TMR_W-1:0] ERASE_CYC = `FCA_ERASE_CYC,
  parameter [`FCA_TMR_W-1:0] SUSP_CYC = `FCA_SUSP_CYC,
  parameter [`FCA_TMR_W-1:0] LKRD_CYC = `FCA_LKRD_CYC
) (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Control
  input wire start_i,
  input wire [`FCA_OP_W-1:0] op_i,
  input wire abort_i,
  // Status
  output reg done_o
);
  reg [`FCA_TMR_W-1:0] cnt_q;
  reg run_q;
  reg [`FCA_TMR_W-1:0] load;

  always @* begin
    case (op_i)
      `FCA_OP_PROGRAM: load = PROG_CYC;
      `FCA_OP_ERASE: load = ERASE_CYC;
      `FCA_OP_SUSPEND: load = SUSP_CYC;
      default: load = LKRD_CYC;
    endcase
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= {`FCA_TMR_W{1'b0}};
      run_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= load;
        run_q <= 1'b1;
      end else if (abort_i) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (cnt_q <= 16'h0001) begin
          run_q <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 16'h0001;
        end
      end
    end
  end
endmodule // fca_busy_timer

// ==== hdl/fca_cmd_decode.v ====
// Acceptance matrix: one-hot state and command code to accept decision
`include "fca_regs.vh"
module fca_cmd_decode (
  // State, one-hot
  input wire [8:0] state_i,
  // Command
  input wire [`FCA_CMD_W-1:0] cmd_i,
  input wire prog_in_erase_ok_i,
  // Decision
  output reg accept_o
);
  // State bit positions match the main module
  wire st_pe = state_i[0];
  wire st_pie = state_i[1];
  wire st_sus = state_i[2];
  wire st_lk2 = state_i[3];
  wire st_psp = state_i[4];
  wire st_esp = state_i[5];
  wire st_lk0 = state_i[6];
  wire st_lk1 = state_i[7];
  wire st_idl = state_i[8];
  wire spd = st_psp | st_esp;

  always @* begin
    accept_o = 1'b0;
    case (cmd_i)
      `FCA_CMD_NORMAL, `FCA_CMD_STATUS_READ, `FCA_CMD_LOCK_READ1: accept_o = spd | st_idl;
      `FCA_CMD_CLOCK_NOTIFY, `FCA_CMD_BLOCK_ERASE: accept_o = st_idl;
      `FCA_CMD_PROGRAM: accept_o = st_idl | (st_esp & prog_in_erase_ok_i);
      `FCA_CMD_SUSPEND: accept_o = st_pe;
      `FCA_CMD_RESUME: accept_o = spd;
      `FCA_CMD_STATUS_CLEAR: accept_o = spd | st_lk1 | st_idl;
      `FCA_CMD_LOCK_READ2: accept_o = st_idl;
      default: accept_o = 1'b0;
    endcase
    if (st_pie | st_sus | st_lk2 | st_lk0) begin
      accept_o = 1'b0;
    end
  end
endmodule // fca_cmd_decode

// ==== verification/fca_accept_properties.sv ====
// Port assertions for the flash command-acceptance block
`include "fca_regs.vh"
module fca_accept_properties (
  // Clock and reset
  input wire clk_i,
  input wire srst_i,
  // Command and enables
  input wire cmd_valid_i,
  input wire [`FCA_CMD_W-1:0] cmd_code_i,
  input wire prog_in_erase_ok_i,
  input wire error_detect_enable_i,
  input wire error_correct_enable_i,
  // Status
  input wire ready_flag_o,
  input wire suspend_ready_flag_o,
  input wire erase_suspended_flag_o,
  input wire program_suspended_flag_o,
  input wire command_lock_flag_o,
  input wire cmd_accepted_o,
  input wire flash_interface_error_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire ok_w = ready_flag_o & ~command_lock_flag_o;
  sequence s_pe_busy;
    !ready_flag_o && suspend_ready_flag_o;
  endsequence
  sequence s_stalled;
    !ready_flag_o && !suspend_ready_flag_o;
  endsequence
  property p_pe_flags;
    s_pe_busy |-> !erase_suspended_flag_o && !program_suspended_flag_o && !command_lock_flag_o;
  endproperty
  property p_idle_prog;
    ok_w && !erase_suspended_flag_o && !program_suspended_flag_o && cmd_valid_i
      && cmd_code_i == `FCA_CMD_PROGRAM |=> cmd_accepted_o ##0 s_pe_busy;
  endproperty
  property p_pe_susp;
    s_pe_busy ##0 cmd_valid_i && cmd_code_i == `FCA_CMD_SUSPEND |=> cmd_accepted_o ##0 s_stalled;
  endproperty
  property p_busy_rej;
    s_stalled ##0 cmd_valid_i |=> !cmd_accepted_o;
  endproperty
  property p_psusp_rej;
    ok_w && program_suspended_flag_o && cmd_valid_i && cmd_code_i inside {`FCA_CMD_PROGRAM,
      `FCA_CMD_BLOCK_ERASE, `FCA_CMD_CLOCK_NOTIFY, `FCA_CMD_SUSPEND} |=> !cmd_accepted_o && command_lock_flag_o;
  endproperty
  property p_esusp_rej;
    ok_w && erase_suspended_flag_o && cmd_valid_i && cmd_code_i inside {`FCA_CMD_BLOCK_ERASE,
      `FCA_CMD_CLOCK_NOTIFY, `FCA_CMD_SUSPEND} |=> !cmd_accepted_o && command_lock_flag_o;
  endproperty
  property p_rlock_rej;
    ready_flag_o && command_lock_flag_o && cmd_valid_i && cmd_code_i != `FCA_CMD_STATUS_CLEAR
      |=> !cmd_accepted_o && command_lock_flag_o;
  endproperty
  property p_rej_lock;
    cmd_valid_i |=> cmd_accepted_o || command_lock_flag_o;
  endproperty
  property p_irq_mask;
    !error_detect_enable_i && !error_correct_enable_i |=> !flash_interface_error_irq_o;
  endproperty
  a_pe_flags: assert property (p_pe_flags) else $error("flags wrong while busy");
  a_idle_prog: assert property (p_idle_prog) else $error("program not started");
  a_pe_susp: assert property (p_pe_susp) else $error("suspend not started");
  a_busy_rej: assert property (p_busy_rej) else $error("busy command taken");
  a_psusp_rej: assert property (p_psusp_rej) else $error("bad command taken");
  a_esusp_rej: assert property (p_esusp_rej) else $error("bad command taken");
  a_rlock_rej: assert property (p_rlock_rej) else $error("locked command taken");
  a_rej_lock: assert property (p_rej_lock) else $error("reject without lock");
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");
endmodule // fca_accept_properties
bind fca_accept fca_accept_properties chk_u (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i),
  .cmd_code_i(cmd_code_i), .prog_in_erase_ok_i(prog_in_erase_ok_i), .error_detect_enable_i(error_detect_enable_i),
  .error_correct_enable_i(error_correct_enable_i), .ready_flag_o(ready_flag_o),
  .suspend_ready_flag_o(suspend_ready_flag_o), .erase_suspended_flag_o(erase_suspended_flag_o),
  .program_suspended_flag_o(program_suspended_flag_o), .command_lock_flag_o(command_lock_flag_o),
  .cmd_accepted_o(cmd_accepted_o), .flash_interface_error_irq_o(flash_interface_error_irq_o));

// ==== verification/fca_accept_bench.sv ====
// Self-checking bench for the flash command-acceptance block
`include "fca_regs.vh"
module fca_accept_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk_i = 1'b0;
  reg srst_i = 1'b1;
  reg cmd_valid_i = 1'b0;
  reg [`FCA_CMD_W-1:0] cmd_code_i = 4'h0;
  reg pe_ok = 1'b0;
  reg det = 1'b0;
  reg cor = 1'b0;
  wire rdy, srdy, esp, psp, lck, acc, irq;
  reg [2:0] st = 3'h0;
  integer seed = 4463;
  integer error_cnt = 0;
  integer compares = 0;
  integer i;
  integer k;
  always #50 clk_i = ~clk_i;
  fca_accept dut_u (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .prog_in_erase_ok_i(pe_ok), .error_detect_enable_i(det), .error_correct_enable_i(cor), .ready_flag_o(rdy),
    .suspend_ready_flag_o(srdy), .erase_suspended_flag_o(esp), .program_suspended_flag_o(psp),
    .command_lock_flag_o(lck), .cmd_accepted_o(acc), .flash_interface_error_irq_o(irq));
  // States: idle, busy, prog-susp, erase-susp, prog in erase-susp, ready-lock, busy-lock, stalled
  function [4:0] fl(input [2:0] s);
    case (s)
      0: fl = 5'h10;
      1: fl = 5'h08;
      2: fl = 5'h12;
      3: fl = 5'h14;
      4: fl = 5'h04;
      5: fl = 5'h11;
      6: fl = 5'h01;
      default: fl = 5'h00;
    endcase
  endfunction
  function ok(input [2:0] s, input [3:0] c);
    case (s)
      0: ok = c != `FCA_CMD_SUSPEND && c != `FCA_CMD_RESUME;
      1: ok = c == `FCA_CMD_SUSPEND;
      2, 3: ok = c <= 4'h2 || c == `FCA_CMD_RESUME || c == `FCA_CMD_STATUS_CLEAR || (s == 3 && c == 4'h4 && pe_ok);
      5: ok = c == `FCA_CMD_STATUS_CLEAR;
      default: ok = 1'b0;
    endcase
  endfunction
  task chk(input [6:0] m, input [6:0] e);
    compares = compares + 1;
    if (({rdy, srdy, esp, psp, lck, acc, irq} & m) !== (e & m)) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: flags %b want %b", $time, {rdy, srdy, esp, psp, lck, acc, irq}, e);
    end
  endtask
  task op(input [3:0] c, input [2:0] nx);
    reg a;
    reg [4:0] f;
    begin
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_code_i <= c;
      det <= $random(seed);
      cor <= $random(seed);
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
      a = ok(st, c);
      f = fl(st);
      if (!a) nx = f[4] ? 3'h5 : 3'h6;
      #1;
      chk(nx >= 5 ? 7'h67 : 7'h7f, {fl(nx), a, !a && !f[0] && (det | cor)});
      st = nx;
    end
  endtask
  task wt(input [2:0] nx);
    for (i = 0; i < 400 && rdy !== 1'b1; i = i + 1) @(posedge clk_i);
    #1;
    chk(7'h7f, {fl(nx), 2'b00});
    st = nx;
  endtask
  task rst;
    $display("test ended at %0t", $time);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    wt(0);
  endtask
  task tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial begin
    rst;
    for (k = 0; k < 8; k = k + 1) op(({$random(seed)} % 5) == 4 ? 4'h8 : 4'({$random(seed)} % 4), 0);
    op(`FCA_CMD_SUSPEND, 0);
    op(`FCA_CMD_RESUME, 0);
    op(`FCA_CMD_STATUS_CLEAR, 0);
    op(`FCA_CMD_PROGRAM, 1);
    op(`FCA_CMD_SUSPEND, 7);
    wt(2);
    op(4'h3 + 4'({$random(seed)} % 4), 2);
    op(`FCA_CMD_STATUS_CLEAR, 2);
    op(`FCA_CMD_STATUS_READ, 2);
    op(`FCA_CMD_RESUME, 1);
    wt(0);
    op(`FCA_CMD_BLOCK_ERASE, 1);
    op(`FCA_CMD_NORMAL, 1);
    rst;
    op(`FCA_CMD_BLOCK_ERASE, 1);
    op(`FCA_CMD_SUSPEND, 7);
    op(`FCA_CMD_CLOCK_NOTIFY, 7);
    rst;
    op(`FCA_CMD_BLOCK_ERASE, 1);
    op(`FCA_CMD_SUSPEND, 7);
    wt(3);
    op(`FCA_CMD_PROGRAM, 3);
    op(`FCA_CMD_STATUS_CLEAR, 3);
    @(posedge clk_i);
    pe_ok <= 1'b1;
    op(`FCA_CMD_PROGRAM, 4);
    op(`FCA_CMD_RESUME, 4);
    rst;
    op(`FCA_CMD_LOCK_READ2, 7);
    op(`FCA_CMD_NORMAL, 7);
    rst;
    tally_and_finish;
  end
endmodule // fca_accept_bench
